// ===== rtl/sar_adc_regs.vh
/*
 * Register offsets, field positions, reset values and timing counts of
 * the converter control block. Definitions only; include by bare name.
 */
`ifndef SAR_ADC_REGS_VH
`define SAR_ADC_REGS_VH

// Register offsets on the plain register port
`define OFS_MODE0 4'h0
`define OFS_CHSEL 4'h1
`define OFS_RES_HIGH 4'h2
`define OFS_RES_LOW 4'h3
`define OFS_IRQ_STATUS 4'h4
`define OFS_IRQ_MASK 4'h5

// Mode register 0 fields
`define BIT_POWER_ON 0
`define BIT_GO 7

// Channel select field
`define CHSEL_W 3

// Reset values
`define RST_BYTE 8'h00

// Result scaling: combined word is value times 64
`define RES_SHIFT 6
`define RES_BITS 10

// Conversion clock divider and phase lengths (conversion clock cycles)
`define CONV_DIV 8'h04
`define SAMPLE_CYCLES 8'h08
`define BIT_CYCLES 8'h02

`endif

// ===== rtl/sar_step.v
/*
 * One successive-approximation step: trial bit set, decision from the
 * comparator. Assumes the comparator output is already synchronised.
 */
`timescale 1ns/1ps
module sar_step
(
  // Present approximation and step position
  input wire [9:0] sar_in,
  input wire [3:0] bit_idx,
  // Comparator result: sampled voltage at least tap voltage
  input wire keep,
  // Trial word for the tap and decided word
  output wire [9:0] trial,
  output reg [9:0] decided
);

  // Trial word sets the bit under test
  assign trial = sar_in | (10'h001 << bit_idx);

  // Keep or drop the trial bit
  always @*
  begin
    decided = trial;
    if (!keep)
      decided[bit_idx] = 1'b0;
  end

endmodule // sar_step

// ===== rtl/sar_adc_ctrl.v
/*
 * Conversion control of a 10-bit successive-approximation converter:
 * stop/standby/converting sequencing, channel select, result registers,
 * done interrupt. Assumes an analog comparator outside that compares the
 * held sample with the tap given by tap_code; cmp_in is asynchronous.
 */
// Functional notes
// - The combined result word is the 10-bit value times 64, left-justified.
// - Setting power-on while stopped moves the converter to standby.
// - At end of conversion result registers load and the done irq rises.
// - After a conversion go clears by hardware and standby returns.
// - Clearing go during conversion aborts it without touching the result.
// - Clearing power-on in standby enters the stop state.
// - A go write while stopped is ignored.
// - A result read coinciding with the result write returns the old value.
// - A mode write at end of conversion wins; result and irq are dropped.
// - Power-on sits at bit 0 of mode register 0.
// - Bits resolve from 9 down to 0, kept when sample is at least the tap.
// - Low result holds two LSBs on top, lower six zero; reset clears both.
// - A 3-bit channel field maps codes 0..7 to inputs 0..7.
`timescale 1ns/1ps
`include "sar_adc_regs.vh"
module sar_adc_ctrl
#(
  parameter CONV_DIV = `CONV_DIV,
  parameter SAMPLE_CYCLES = `SAMPLE_CYCLES,
  parameter BIT_CYCLES = `BIT_CYCLES
)
(
  // Clock and reset
  input wire sys_clk,
  input wire arst_n,
  // Register port
  input wire [3:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  // Analog front end
  input wire cmp_in,
  output reg [2:0] channel_sel,
  output reg sample_en,
  output reg [9:0] tap_code,
  output reg converter_powered,
  // Interrupt
  output wire conversion_done_irq
);

  localparam ST_STOP = 3'b001;
  localparam ST_STANDBY = 3'b010;
  localparam ST_CONV = 3'b100;

  reg [2:0] state_q;
  reg converter_power_on_q;
  reg conversion_go_q;
  reg [2:0] channel_select_q;
  reg [9:0] approximation_q;
  reg [7:0] result_high_byte_q;
  reg [1:0] result_low_q;
  reg irq_status_q;
  reg irq_mask_q;
  reg [7:0] div_q;
  reg [7:0] phase_cnt_q;
  reg sampling_q;
  reg [3:0] bit_idx_q;
  reg cmp_meta_q;
  reg cmp_sync_q;
  reg done_pending_q;
  reg [9:0] pending_val_q;
  wire conv_tick;
  wire [9:0] trial_w;
  wire [9:0] decided_w;
  wire mode_wr;
  wire res_rd;
  wire [15:0] combined_result_word;
  reg end_conv;

  assign mode_wr = reg_wr && (reg_addr == `OFS_MODE0);
  assign res_rd = reg_rd && ((reg_addr == `OFS_RES_HIGH) ||
                  (reg_addr == `OFS_RES_LOW));

  // left-justify; the final decision or the deferred one
  assign combined_result_word = {end_conv ? decided_w : pending_val_q,
                                 6'h00};

  // Comparator pin crosses into the clock domain first
  always @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cmp_meta_q <= 1'b0;
      cmp_sync_q <= 1'b0;
    end
    else
    begin
      cmp_meta_q <= cmp_in;
      cmp_sync_q <= cmp_meta_q;
    end
  end

  // Conversion clock enable; runs only while converting
  assign conv_tick = (div_q == CONV_DIV - 1);
  always @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      div_q <= 8'h00;
    else if (state_q != ST_CONV || conv_tick)
      div_q <= 8'h00;
    else
      div_q <= div_q + 8'h01;
  end

  sar_step u_step
  (
    .sar_in(approximation_q),
    .bit_idx(bit_idx_q),
    .keep(cmp_sync_q),
    .trial(trial_w),
    .decided(decided_w)
  );

  // Last bit decided on this tick; a cleared go or power-on has
  // already aborted, so no result may land on that edge
  always @*
  begin
    end_conv = (state_q == ST_CONV) && conv_tick && !sampling_q &&
               conversion_go_q && converter_power_on_q &&
               (phase_cnt_q == BIT_CYCLES - 1) && (bit_idx_q == 4'h0);
  end

  // Tap and sample outputs from flops
  always @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sample_en <= 1'b0;
      tap_code <= 10'h000;
      channel_sel <= 3'h0;
      converter_powered <= 1'b0;
    end
    else
    begin
      sample_en <= (state_q == ST_CONV) && sampling_q;
      tap_code <= trial_w;
      channel_sel <= channel_select_q;
      converter_powered <= converter_power_on_q;
    end
  end

  // Control state, mode bits and the approximation sequence
  always @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_q <= ST_STOP;
      converter_power_on_q <= 1'b0;
      conversion_go_q <= 1'b0;
      approximation_q <= 10'h000;
      phase_cnt_q <= 8'h00;
      sampling_q <= 1'b0;
      bit_idx_q <= 4'h9;
    end
    else
    begin
      case (state_q)
        ST_STOP:
        begin
          if (converter_power_on_q)
            state_q <= ST_STANDBY;
        end
        ST_STANDBY:
        begin
          if (!converter_power_on_q)
            state_q <= ST_STOP;
          else if (conversion_go_q)
          begin
            state_q <= ST_CONV;
            approximation_q <= 10'h000;
            phase_cnt_q <= 8'h00;
            sampling_q <= 1'b1;
            bit_idx_q <= 4'h9;
          end
        end
        ST_CONV:
        begin
          if (!conversion_go_q || !converter_power_on_q)
            state_q <= ST_STANDBY;
          else if (conv_tick)
          begin
            if (sampling_q)
            begin
              if (phase_cnt_q == SAMPLE_CYCLES - 1)
              begin
                sampling_q <= 1'b0;
                phase_cnt_q <= 8'h00;
              end
              else
                phase_cnt_q <= phase_cnt_q + 8'h01;
            end
            else if (phase_cnt_q == BIT_CYCLES - 1)
            begin
              // keep bit when sample at least tap
              approximation_q <= decided_w;
              phase_cnt_q <= 8'h00;
              if (bit_idx_q == 4'h0)
                state_q <= ST_STANDBY;
              else
                bit_idx_q <= bit_idx_q - 4'h1;
            end
            else
              phase_cnt_q <= phase_cnt_q + 8'h01;
          end
        end
        default:
          state_q <= ST_STOP;
      endcase
      // Software write to mode register 0 is taken last and wins
      if (mode_wr)
      begin
        converter_power_on_q <= reg_wdata[`BIT_POWER_ON];
        // go ignored while stopped
        // Stopped means power-on clear, whatever the state shows
        conversion_go_q <= reg_wdata[`BIT_GO] && converter_power_on_q;
      end
      else if (end_conv)
        conversion_go_q <= 1'b0;
    end
  end

  // Result registers, deferred by one cycle when a read collides
  always @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      result_high_byte_q <= `RST_BYTE;
      result_low_q <= 2'b00;
      done_pending_q <= 1'b0;
      pending_val_q <= 10'h000;
    end
    else if (end_conv && mode_wr)
      done_pending_q <= 1'b0;
    else if (end_conv && res_rd)
    begin
      done_pending_q <= 1'b1;
      pending_val_q <= decided_w;
    end
    else if (end_conv || done_pending_q)
    begin
      result_high_byte_q <= combined_result_word[15:8];
      result_low_q <= combined_result_word[7:6];
      done_pending_q <= 1'b0;
    end
  end

  // Sticky done flag; set wins over write-one clear
  always @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      irq_status_q <= 1'b0;
      irq_mask_q <= 1'b0;
    end
    else
    begin
      // done irq raised with the result
      if (end_conv && !mode_wr)
        irq_status_q <= 1'b1;
      else if (reg_wr && reg_addr == `OFS_IRQ_STATUS && reg_wdata[0])
        irq_status_q <= 1'b0;
      if (reg_wr && reg_addr == `OFS_IRQ_MASK)
        irq_mask_q <= reg_wdata[0];
    end
  end

  assign conversion_done_irq = irq_status_q & irq_mask_q;

  // Channel select register
  always @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      channel_select_q <= 3'h0;
    else if (reg_wr && reg_addr == `OFS_CHSEL)
      channel_select_q <= reg_wdata[`CHSEL_W-1:0];
  end

  // Read data one cycle after the strobe; unmapped reads as zero
  always @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      reg_rdata <= 8'h00;
    else if (reg_rd)
    begin
      case (reg_addr)
        `OFS_MODE0:
          reg_rdata <= {conversion_go_q, 6'h00, converter_power_on_q};
        `OFS_CHSEL: reg_rdata <= {5'h00, channel_select_q};
        `OFS_RES_HIGH: reg_rdata <= result_high_byte_q;
        `OFS_RES_LOW: reg_rdata <= {result_low_q, 6'h00};
        `OFS_IRQ_STATUS: reg_rdata <= {7'h00, irq_status_q};
        `OFS_IRQ_MASK: reg_rdata <= {7'h00, irq_mask_q};
        default: reg_rdata <= 8'h00;
      endcase
    end
    else
      reg_rdata <= 8'h00;
  end

endmodule // sar_adc_ctrl

// ===== dv/sar_adc_ctrl_checker.sv
/* Port checker of the converter control: read port, irq and sequencing.
   Assumes the register header is on the include path; bound below. */
`timescale 1ns/1ps
`include "sar_adc_regs.vh"
module sar_adc_ctrl_checker
(
  // Clock and reset
  input wire sys_clk,
  input wire arst_n,
  // Register port
  input wire [3:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_rdata,
  // Front end and interrupt
  input wire sample_en,
  input wire converter_powered,
  input wire conversion_done_irq
);
  // One domain, so one clock and one disable for all
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  // Read data only in the answer cycle
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside a read answer");
  a_unmapped_zero: assert property (reg_rd && reg_addr > `OFS_IRQ_MASK
    |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
  a_low_zero: assert property (
    reg_rd && reg_addr == `OFS_RES_LOW |=> reg_rdata[5:0] == 6'h00)
    else $error("low result lower bits not zero");
  a_chsel_zero: assert property (
    reg_rd && reg_addr == `OFS_CHSEL |=> reg_rdata[7:3] == 5'h00)
    else $error("channel select upper bits not zero");
  // Power bit follows mode writes; stop may pass through standby first
  a_power_follows: assert property (
    reg_wr && reg_addr == `OFS_MODE0 && reg_wdata[0]
    |-> ##[1:2] converter_powered) else $error("power-on not taken");
  a_power_drops: assert property (
    reg_wr && reg_addr == `OFS_MODE0 && !reg_wdata[0]
    |-> ##[1:4] !converter_powered) else $error("stop not entered");
  a_go_ignored: assert property (
    reg_wr && reg_addr == `OFS_MODE0 && reg_wdata[7]
    && !converter_powered && !$past(reg_wr) |=> !sample_en [*8])
    else $error("conversion started while stopped");
  a_start_powered: assert property (
    $rose(sample_en) |-> converter_powered)
    else $error("sampling without power-on");
  // Level irq stands until cleared or masked
  a_irq_stands: assert property (
    conversion_done_irq && !(reg_wr && (reg_addr == `OFS_IRQ_STATUS
    || reg_addr == `OFS_IRQ_MASK)) |=> conversion_done_irq)
    else $error("irq dropped without clear or mask");
  a_mask_off: assert property (reg_wr && reg_addr == `OFS_IRQ_MASK
    && !reg_wdata[0] |=> !conversion_done_irq)
    else $error("masked irq still high");
endmodule // sar_adc_ctrl_checker

bind sar_adc_ctrl sar_adc_ctrl_checker u_chk (.sys_clk(sys_clk),
  .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .sample_en(sample_en), .converter_powered(converter_powered),
  .conversion_done_irq(conversion_done_irq));

// ===== dv/tb_top.sv
/* Self-checking bench of the converter control with an ideal comparator.
   Assumes the design, its header and the checker are compiled first. */
`timescale 1ns/1ps
`include "sar_adc_regs.vh"
module tb_top;
  // Design inputs, all defined at time zero
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  // Design outputs
  logic [7:0] reg_rdata;
  logic [2:0] channel_sel;
  logic sample_en;
  logic [9:0] tap_code;
  logic converter_powered;
  logic conversion_done_irq;
  // Bench state
  logic [9:0] level = 10'h000;
  logic [9:0] prev;
  logic rd_seen = 1'b0;
  logic [7:0] exp_q[$];
  integer err_total = 0;
  integer cmp_count = 0;
  integer seed = 82488;
  integer i;
  // Write edge to end-of-conversion edge at the default timing
  localparam int END_GAP = 1 + `CONV_DIV * (`SAMPLE_CYCLES +
    `RES_BITS * `BIT_CYCLES);
  // Ideal comparator: held level at least the trial tap
  wire cmp_in = (level >= tap_code);

  // 25 MHz clock
  always #20 sys_clk = ~sys_clk;

  sar_adc_ctrl u_dut (.sys_clk(sys_clk), .arst_n(arst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cmp_in(cmp_in),
    .channel_sel(channel_sel), .sample_en(sample_en),
    .tap_code(tap_code), .converter_powered(converter_powered),
    .conversion_done_irq(conversion_done_irq));

  task automatic chk(input string what, input logic [15:0] seen,
    input logic [15:0] want);
    cmp_count++;
    if (seen !== want)
    begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, want, seen);
    end
  endtask

  // Bus cycles; each leaves an idle edge so strobes never double up
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] want);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    exp_q.push_back(want);
    @(posedge sys_clk);
    reg_rd <= 1'b0;
  endtask

  // Bounded wait, sampled mid-cycle so the edge updates have landed
  task automatic wait_irq;
    integer n;
    n = 0;
    while (conversion_done_irq !== 1'b1 && n < 1000)
    begin
      @(negedge sys_clk);
      n++;
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Read watcher: data stand only in the cycle after the strobe
  always @(posedge sys_clk) rd_seen <= reg_rd;
  always @(negedge sys_clk)
    if (rd_seen)
      chk("reg_rdata", {8'h00, reg_rdata}, {8'h00, exp_q.pop_front()});

  // Hang guard, well past the expected run of some 1750 cycles
  initial
  begin
    #800000;
    err_total++;
    report_and_stop();
  end

  // Main sequence
  initial
  begin
    repeat (2) @(posedge sys_clk);
    arst_n <= 1'b1;
    rd(`OFS_RES_HIGH, `RST_BYTE);
    rd(`OFS_RES_LOW, `RST_BYTE);
    rd(4'hf, 8'h00);
    // Refused start while stopped
    wr(`OFS_MODE0, 8'h81); // go only with power-on
    repeat (40) @(negedge sys_clk);
    chk("sample_en", 16'(sample_en), 16'h0000);
    rd(`OFS_MODE0, 8'h01);
    wr(`OFS_IRQ_MASK, 8'h01);
    wr(`OFS_MODE0, 8'h01);
    repeat (3) @(negedge sys_clk);
    chk("converter_powered", 16'(converter_powered), 16'h0001);
    // Full scale, zero, then random levels, one per channel
    for (i = 0; i < 8; i++)
    begin
      level <= (i == 0) ? 10'h3ff : (i == 1) ? 10'h000 : 10'($random(seed));
      wr(`OFS_CHSEL, 8'(i));
      wr(`OFS_MODE0, 8'h81);
      wait_irq();
      chk("irq", 16'(conversion_done_irq), 16'h0001);
      chk("channel_sel", 16'(channel_sel), 16'(i));
      rd(`OFS_MODE0, 8'h01);
      rd(`OFS_RES_HIGH, level[9:2]);
      rd(`OFS_RES_LOW, {level[1:0], 6'h00});
      rd(`OFS_IRQ_STATUS, 8'h01);
      rd(`OFS_CHSEL, 8'(i));
      wr(`OFS_IRQ_MASK, 8'h00);
      @(negedge sys_clk);
      chk("irq", 16'(conversion_done_irq), 16'h0000);
      wr(`OFS_IRQ_MASK, 8'h01);
      @(negedge sys_clk);
      chk("irq", 16'(conversion_done_irq), 16'h0001);
      wr(`OFS_IRQ_STATUS, 8'h01);
      @(negedge sys_clk);
      chk("irq", 16'(conversion_done_irq), 16'h0000);
    end
    // Read on the end edge gets the old value, then the new one
    prev = level;
    level <= ~level;
    wr(`OFS_MODE0, 8'h81);
    repeat (END_GAP - 2) @(posedge sys_clk);
    rd(`OFS_RES_HIGH, prev[9:2]);
    rd(`OFS_RES_HIGH, ~prev[9:2]);
    rd(`OFS_IRQ_STATUS, 8'h01);
    wr(`OFS_IRQ_STATUS, 8'h01);
    // Abort during sampling keeps the old result and raises nothing
    prev = level;
    level <= ~level;
    wr(`OFS_MODE0, 8'h81);
    repeat (20) @(posedge sys_clk);
    wr(`OFS_MODE0, 8'h01);
    repeat (300) @(posedge sys_clk);
    rd(`OFS_RES_HIGH, prev[9:2]);
    rd(`OFS_RES_LOW, {prev[1:0], 6'h00});
    rd(`OFS_IRQ_STATUS, 8'h00);
    rd(`OFS_MODE0, 8'h01);
    // Mode write on the end edge wins: no result, no irq
    wr(`OFS_MODE0, 8'h81);
    repeat (END_GAP - 2) @(posedge sys_clk);
    wr(`OFS_MODE0, 8'h01);
    repeat (4) @(posedge sys_clk);
    rd(`OFS_RES_HIGH, prev[9:2]);
    rd(`OFS_IRQ_STATUS, 8'h00);
    rd(`OFS_MODE0, 8'h01);
    // Back to stop from standby
    wr(`OFS_MODE0, 8'h00);
    repeat (4) @(negedge sys_clk);
    chk("converter_powered", 16'(converter_powered), 16'h0000);
    repeat (3) @(posedge sys_clk);
    report_and_stop();
  end
endmodule // tb_top
